// *** compact_timer_module_core.sv ***
/*
 Compact 10-bit timer core: counter, period and compare-A comparators,
 byte-buffered register pairs, compare and PWM output, paired output pins.
 Assumes the high clock enable pulse comes from the clock generator on ref_clk,
 and the sub clock and external count pin are asynchronous levels.
*/
// The address-and-strobe port and the address map were decided locally.
`include "compact_timer_params.svh"
`default_nettype none
module compact_timer_module_core
	import compact_timer_pkg::*;
(
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	// Register port
	input  wire logic [`CT_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [7:0]            reg_rdata,
	// Clock sources
	input  wire logic                  high_clock_tick,
	input  wire logic                  sub_clock,
	input  wire logic                  external_count_clock_pin,
	// Timer outputs
	output logic                       timer_output,
	output logic                       timer_output_inverted,
	output logic                       compare_a_irq,
	output logic                       compare_p_irq
);

	timer_state_s st_reg;
	timer_state_s st_next;

	function automatic logic [7:0] pair_high(input logic [9:0] v);
		pair_high = {6'h00, v[9:8]};
	endfunction : pair_high

	logic       pause;
	logic [2:0] clk_sel;
	logic       module_on;
	logic [2:0] period_match_bits;
	op_mode_e   operating_mode_select;
	logic [1:0] out_func;
	logic       init_lvl;
	logic       out_pol;
	logic       duty_swap;
	logic       counter_clear_select;
	logic       on_rise;
	logic       tick;
	logic       match_a;
	logic       match_p;
	logic       wrap;
	logic       clr_evt;
	logic       lvl;
	logic       duty_hit;

	always_comb begin
		pause                 = st_reg.ctrl0[`CT_BIT_PAUSE];
		clk_sel               = st_reg.ctrl0[6:4];
		module_on             = st_reg.ctrl0[`CT_BIT_ON];
		period_match_bits     = st_reg.ctrl0[2:0];
		operating_mode_select = op_mode_e'(st_reg.ctrl1[7:6]);
		out_func              = st_reg.ctrl1[5:4];
		init_lvl              = st_reg.ctrl1[`CT_BIT_OC];
		out_pol               = st_reg.ctrl1[`CT_BIT_POL];
		duty_swap             = st_reg.ctrl1[`CT_BIT_DPX];
		counter_clear_select  = st_reg.ctrl1[`CT_BIT_CCLR];
	end

	always_comb begin
		st_next = st_reg;
		on_rise = 1'b0;
		tick    = 1'b0;
		lvl     = st_reg.out_lvl;
		duty_hit = 1'b0;

		// Prescalers run continuously so the selected rate is steady on switch-over
		st_next.sys_div = st_reg.sys_div + 2'h1;
		if (high_clock_tick) begin
			st_next.hi_div = st_reg.hi_div + 6'h01;
		end

		// Only the second and third stages are compared, never the first
		st_next.pin_sync = {st_reg.pin_sync[1:0], external_count_clock_pin};
		st_next.sub_sync = {st_reg.sub_sync[1:0], sub_clock};
		if (st_reg.pin_sync[1] == st_reg.pin_sync[2]) begin
			st_next.pin_state = st_reg.pin_sync[2];
		end
		if (st_reg.sub_sync[1] == st_reg.sub_sync[2]) begin
			st_next.sub_state = st_reg.sub_sync[2];
		end

		unique case (clk_sel)
			`CT_CK_SYS_DIV4: tick = (st_reg.sys_div == 2'(`CT_SYS_DIV - 1));
			`CT_CK_SYS:      tick = 1'b1;
			`CT_CK_HI_DIV16: tick = high_clock_tick
				&& (st_reg.hi_div[3:0] == 4'(`CT_HI_DIV16 - 1));
			`CT_CK_HI_DIV64: tick = high_clock_tick
				&& (st_reg.hi_div == 6'(`CT_HI_DIV64 - 1));
			`CT_CK_SUB_A,
			`CT_CK_SUB_B:    tick = st_next.sub_state && !st_reg.sub_state;
			`CT_CK_PIN_RISE: tick = st_next.pin_state && !st_reg.pin_state;
			`CT_CK_PIN_FALL: tick = !st_next.pin_state && st_reg.pin_state;
		endcase
		tick = tick && module_on && !pause;

		// Comparators look at the count as it stands before the tick advances it
		match_a  = tick && (st_reg.count == st_reg.cmp_a);
		// Period 000 never matches; the wrap at full count stands in for it
		match_p  = tick && period_match_bits != 3'h0
			&& (st_reg.count[9:7] == period_match_bits);
		wrap     = tick && (st_reg.count == `CT_CNT_MAX);
		clr_evt  = 1'b0;

		if (tick) begin
			st_next.count = st_reg.count + 10'h001;
			if (operating_mode_select == MODE_PWM) begin
				// Period comparator ends the cycle; DPX swaps which one is period
				clr_evt = duty_swap ? match_a : (match_p || wrap);
			end else if (counter_clear_select) begin
				// A zero compare value would pin the count at zero; let it overflow
				clr_evt = match_a && st_reg.cmp_a != 10'h000;
			end else begin
				clr_evt = (match_p && period_match_bits != 3'h0) || wrap;
			end
			if (clr_evt) begin
				st_next.count = 10'h000;
			end
		end

		// Interrupt requests follow the matches; clear select A suppresses P
		st_next.irq_a = match_a && !(st_reg.cmp_a == 10'h000 && counter_clear_select);
		st_next.irq_p = (match_p || (wrap && period_match_bits == 3'h0))
			&& !counter_clear_select;
		st_next.flag_a = st_reg.flag_a | st_next.irq_a;
		st_next.flag_p = st_reg.flag_p | st_next.irq_p;

		unique case (operating_mode_select)
			MODE_CMP_OUT: begin
				if (match_a) begin
					unique case (out_func)
						2'h0: lvl = st_reg.out_lvl;
						2'h1: lvl = 1'b0;
						2'h2: lvl = 1'b1;
						2'h3: lvl = !st_reg.out_lvl;
					endcase
				end
			end
			MODE_PWM: begin
				duty_hit = duty_swap ? (st_reg.count[9:7] < period_match_bits)
					: (st_reg.count < st_reg.cmp_a);
				unique case (out_func)
					2'h0: lvl = !init_lvl;
					2'h1: lvl = init_lvl;
					2'h2: lvl = duty_hit ? init_lvl : !init_lvl;
					2'h3: lvl = st_reg.out_lvl;
				endcase
			end
			MODE_UNDEF,
			MODE_TIMER: lvl = st_reg.out_lvl;
		endcase
		st_next.out_lvl = lvl;

		// Register port
		st_next.rd_data = 8'h00;
		if (reg_wr) begin
			unique case (reg_addr)
				`CT_OFF_CTRL0: begin
					st_next.ctrl0 = reg_wdata;
					on_rise = reg_wdata[`CT_BIT_ON] && !module_on;
				end
				`CT_OFF_CTRL1:   st_next.ctrl1 = reg_wdata;
				`CT_OFF_CMPA_LO: st_next.low_buf = reg_wdata;
				`CT_OFF_CMPA_HI: st_next.cmp_a = {reg_wdata[1:0], st_reg.low_buf};
				`CT_OFF_STATUS: begin
					// Write one to clear; a new event in the same cycle wins
					st_next.flag_a = (st_reg.flag_a && !reg_wdata[0]) || st_next.irq_a;
					st_next.flag_p = (st_reg.flag_p && !reg_wdata[1]) || st_next.irq_p;
				end
				// Counter pair is read-only and ignores writes
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`CT_OFF_CTRL0:   st_next.rd_data = st_reg.ctrl0;
				`CT_OFF_CTRL1:   st_next.rd_data = st_reg.ctrl1;
				`CT_OFF_CNT_HI: begin
					st_next.rd_data = pair_high(st_reg.count);
					st_next.low_buf = st_reg.count[7:0];
				end
				`CT_OFF_CMPA_HI: begin
					st_next.rd_data = pair_high(st_reg.cmp_a);
					st_next.low_buf = st_reg.cmp_a[7:0];
				end
				`CT_OFF_CNT_LO,
				`CT_OFF_CMPA_LO: st_next.rd_data = st_reg.low_buf;
				`CT_OFF_STATUS:  st_next.rd_data = {6'h00, st_reg.flag_p, st_reg.flag_a};
				default:         st_next.rd_data = 8'h00;
			endcase
		end

		if (on_rise) begin
			st_next.count   = 10'h000;
			st_next.out_lvl = init_lvl;
		end

		st_next.pin_out   = st_next.out_lvl ^ out_pol;
		st_next.pin_out_b = !(st_next.out_lvl ^ out_pol);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg           <= '0;
			st_reg.ctrl0     <= `CT_CTRL0_RESET;
			st_reg.ctrl1     <= `CT_CTRL1_RESET;
			st_reg.pin_out_b <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	always_comb begin
		reg_rdata             = st_reg.rd_data;
		timer_output          = st_reg.pin_out;
		timer_output_inverted = st_reg.pin_out_b;
		compare_a_irq         = st_reg.irq_a;
		compare_p_irq         = st_reg.irq_p;
	end

endmodule : compact_timer_module_core
`default_nettype wire

// *** compact_timer_params.svh ***
/*
 Register offsets, field positions, reset values and clock-select codes for the
 compact 10-bit timer core.
 Assumes a plain byte-wide register port with one-cycle strobes.
*/
`ifndef COMPACT_TIMER_PARAMS_SVH
`define COMPACT_TIMER_PARAMS_SVH

`define CT_ADDR_W        3
`define CT_OFF_CTRL0     3'h0
`define CT_OFF_CTRL1     3'h1
`define CT_OFF_CNT_LO    3'h2
`define CT_OFF_CNT_HI    3'h3
`define CT_OFF_CMPA_LO   3'h4
`define CT_OFF_CMPA_HI   3'h5
`define CT_OFF_STATUS    3'h6

`define CT_CTRL0_RESET   8'h00
`define CT_CTRL1_RESET   8'h00

`define CT_BIT_PAUSE     7
`define CT_BIT_ON        3
`define CT_BIT_OC        3
`define CT_BIT_POL       2
`define CT_BIT_DPX       1
`define CT_BIT_CCLR      0

`define CT_CK_SYS_DIV4   3'h0
`define CT_CK_SYS        3'h1
`define CT_CK_HI_DIV16   3'h2
`define CT_CK_HI_DIV64   3'h3
`define CT_CK_SUB_A      3'h4
`define CT_CK_SUB_B      3'h5
`define CT_CK_PIN_RISE   3'h6
`define CT_CK_PIN_FALL   3'h7

`define CT_SYS_DIV       4'h4
`define CT_HI_DIV16      6'h10
`define CT_HI_DIV64      7'h40
`define CT_CNT_MAX       10'h3FF

`endif

// *** compact_timer_pkg.sv ***
/*
 Types shared by the compact timer core.
 Assumes compact_timer_params.svh for all numeric constants except the operating-mode codes of op_mode_e.
*/
`default_nettype none
package compact_timer_pkg;

	typedef enum logic [1:0] {
		MODE_CMP_OUT = 2'h0,
		MODE_UNDEF   = 2'h1,
		MODE_PWM     = 2'h2,
		MODE_TIMER   = 2'h3
	} op_mode_e;

	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [9:0] count;
		logic [9:0] cmp_a;
		logic [7:0] low_buf;
		logic [7:0] rd_data;
		logic [1:0] sys_div;
		logic [5:0] hi_div;
		logic [2:0] pin_sync;
		logic       pin_state;
		logic [2:0] sub_sync;
		logic       sub_state;
		logic       out_lvl;
		logic       pin_out;
		logic       pin_out_b;
		logic       flag_a;
		logic       flag_p;
		logic       irq_a;
		logic       irq_p;
	} timer_state_s;

endpackage : compact_timer_pkg
`default_nettype wire

// *** compact_timer_checker.sv ***
/*
 Port checker for the compact timer core.
 Assumes a bind onto compact_timer_module_core.
*/
`include "compact_timer_params.svh"
`default_nettype none
module compact_timer_checker (
	// Clock, reset, register port
	input wire logic                  ref_clk,
	input wire logic                  rst_b,
	input wire logic [`CT_ADDR_W-1:0] reg_addr,
	input wire logic [7:0]            reg_wdata,
	input wire logic                  reg_wr,
	input wire logic                  reg_rd,
	input wire logic [7:0]            reg_rdata,
	// Timer outputs
	input wire logic                  timer_output,
	input wire logic                  timer_output_inverted,
	input wire logic                  compare_a_irq,
	input wire logic                  compare_p_irq
);
	logic [7:0] ctrl0_reg;
	logic [7:0] ctrl1_reg;
	logic [1:0] cmp_hi_reg;
	wire logic  stopped = ctrl0_reg[`CT_BIT_PAUSE] | ~ctrl0_reg[`CT_BIT_ON];
	// PWM clears on its period compare, not the clear select, so it is left out here
	wire logic  clr_a = ctrl1_reg[`CT_BIT_CCLR] & (ctrl1_reg[7:6] != 2'h2);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl0_reg <= `CT_CTRL0_RESET;
			ctrl1_reg <= `CT_CTRL1_RESET;
			cmp_hi_reg <= 2'h0;
		end else if (reg_wr) begin
			if (reg_addr == `CT_OFF_CTRL0) ctrl0_reg <= reg_wdata;
			if (reg_addr == `CT_OFF_CTRL1) ctrl1_reg <= reg_wdata;
			if (reg_addr == `CT_OFF_CMPA_HI) cmp_hi_reg <= reg_wdata[1:0];
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	a_out_inverse: assert property (timer_output_inverted == !timer_output)
		else $error("inverted output does not mirror primary output");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read answer");
	a_ctrl_read: assert property (reg_rd && reg_addr == `CT_OFF_CTRL0
		|=> reg_rdata == ctrl0_reg)
		else $error("control read differs from value written");
	a_cnt_hi_zeros: assert property (reg_rd && reg_addr == `CT_OFF_CNT_HI
		|=> reg_rdata[7:2] == 6'h00)
		else $error("counter high byte upper bits not zero");
	a_cmpa_hi_read: assert property (reg_rd && reg_addr == `CT_OFF_CMPA_HI
		|=> reg_rdata == {6'h00, cmp_hi_reg})
		else $error("compare high byte read wrong");
	a_cmpa_lo_load: assert property ((reg_wr && reg_addr == `CT_OFF_CMPA_LO)
		##1 (reg_wr && reg_addr == `CT_OFF_CMPA_HI) ##1 (reg_rd && reg_addr == `CT_OFF_CMPA_HI)
		##1 (reg_rd && reg_addr == `CT_OFF_CMPA_LO) |=> reg_rdata == $past(reg_wdata, 4))
		else $error("compare low byte not carried through buffer");
	a_irq_a_pulse: assert property (compare_a_irq |=> !compare_a_irq)
		else $error("compare A request longer than one cycle");
	a_p_gated: assert property (clr_a && $past(clr_a) |-> !compare_p_irq)
		else $error("period request while clearing on compare A");
	a_stop_no_irq: assert property (stopped [*3] |-> !compare_a_irq && !compare_p_irq)
		else $error("request while counter stopped");

	c_irq_a: cover property (compare_a_irq);
	c_irq_p: cover property (compare_p_irq);
	c_paused_read: cover property (stopped && reg_rd && reg_addr == `CT_OFF_CNT_HI);
endmodule : compact_timer_checker

bind compact_timer_module_core compact_timer_checker compact_timer_checker_i (
	.ref_clk               (ref_clk),
	.rst_b                 (rst_b),
	.reg_addr              (reg_addr),
	.reg_wdata             (reg_wdata),
	.reg_wr                (reg_wr),
	.reg_rd                (reg_rd),
	.reg_rdata             (reg_rdata),
	.timer_output          (timer_output),
	.timer_output_inverted (timer_output_inverted),
	.compare_a_irq         (compare_a_irq),
	.compare_p_irq         (compare_p_irq)
);
`default_nettype wire

// *** tb.sv ***
/*
 Self-checking bench for the compact timer core.
 Assumes the core, its package and its checker are compiled first.
*/
`default_nettype none
module tb
	import compact_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk   = 1'b0;
	logic       rst_b     = 1'b0;
	logic       reg_wr    = 1'b0;
	logic       reg_rd    = 1'b0;
	logic       tick      = 1'b0;
	logic       sub_clock = 1'b0;
	logic [2:0] reg_addr  = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic       timer_output, timer_output_inverted, compare_a_irq, compare_p_irq;
	int         miscompares, tests_run, cyc, div;
	int         seed      = 32'h7918;
	logic [2:0] ra[8]     = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h5, 3'h4, 3'h7, 3'h7};
	logic [7:0] c1[3]     = '{8'h31, 8'h21, 8'h19};

	compact_timer_module_core compact_timer_module_core_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .high_clock_tick(tick),
		.sub_clock(sub_clock), .external_count_clock_pin(sub_clock),
		.timer_output(timer_output), .timer_output_inverted(timer_output_inverted),
		.compare_a_irq(compare_a_irq), .compare_p_irq(compare_p_irq));

	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// High tick every 2 cycles; sub clock and pin share a period of 6
	always @(posedge ref_clk) begin
		div <= (div == 5) ? 0 : div + 1;
		tick <= !div[0];
		sub_clock <= div < 3;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic chk(input string what, input logic [9:0] exp, got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_gap(input string what, input int exp, got);
		tests_run++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask : chk_gap
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic idle(input int k);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (k) @(posedge ref_clk);
	endtask : idle
	task automatic rd2(input logic [2:0] a, b, output logic [7:0] x, y);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		@(posedge ref_clk);
		reg_addr <= b;
		#1 x = reg_rdata;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 y = reg_rdata;
		@(posedge ref_clk);
	endtask : rd2
	task automatic wait_irq(input bit p, output int k);
		// Strobes are one cycle long; drop any left high by the last write
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1 k++;
		end while ((p ? compare_p_irq : compare_a_irq) !== 1'b1 && k < 3000);
		if (k >= 3000) chk("request wait", 10'h001, 10'h000);
	endtask : wait_irq
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial begin
		logic [7:0] h, l, c;
		logic [9:0] r;
		int         g, m;
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			rd2(ra[2 * i], ra[2 * i + 1], h, l);
			chk("reset high", 10'h000, 10'(h));
			chk("reset low", 10'h000, 10'(l));
		end
		r = 10'($random(seed));
		wr(3'h4, r[7:0]);
		wr(3'h5, {6'($random(seed)), r[9:8]});
		rd2(3'h5, 3'h4, h, l);
		chk("compare high", 10'(r[9:8]), 10'(h));
		chk("compare low", 10'(r[7:0]), 10'(l));
		$display("test done: registers");
		for (int s = 0; s < 8; s++) begin
			m = s == 0 ? 4 : s == 1 ? 1 : s == 2 ? 32 : s == 3 ? 128 : 6;
			c = c1[s % 3];
			r = 10'(3 + ($random(seed) & 3));
			wr(3'h0, 8'h00);
			wr(3'h1, c);
			wr(3'h4, r[7:0]);
			wr(3'h5, 8'h00);
			wr(3'h0, {1'b0, 3'(s), 4'h8});
			idle(2);
			#1 chk("initial level", 10'(c[3]), 10'(timer_output));
			wait_irq(1'b0, g);
			idle(2);
			#1 chk("first match level", 10'(s % 3 != 2), 10'(timer_output));
			wait_irq(1'b0, g);
			idle(2);
			#1 chk("second match level", 10'(s % 3 == 1), 10'(timer_output));
			wait_irq(1'b0, g);
			chk_gap("match spacing", m * (r + 1) - 2, g);
		end
		$display("test done: clock sources");
		wr(3'h0, 8'h00);
		wr(3'h1, 8'hC0);
		wr(3'h0, 8'h19);
		wait_irq(1'b1, g);
		wait_irq(1'b1, g);
		chk_gap("period spacing", 128 + 1, g);
		wr(3'h0, 8'h18);
		wait_irq(1'b1, g);
		wait_irq(1'b1, g);
		chk_gap("overflow spacing", 1024, g);
		$display("test done: period");
		wr(3'h0, 8'h98);
		rd2(3'h3, 3'h2, h, l);
		r = {h[1:0], l};
		wr(3'h3, 8'h03);
		wr(3'h2, 8'hFF);
		rd2(3'h3, 3'h2, h, l);
		chk("paused count", r, {h[1:0], l});
		wr(3'h0, 8'h18);
		idle(5);
		wr(3'h0, 8'h10);
		rd2(3'h3, 3'h2, h, l);
		r = {h[1:0], l};
		idle(5);
		rd2(3'h3, 3'h2, h, l);
		chk("stopped count", r, {h[1:0], l});
		wr(3'h0, 8'h98);
		rd2(3'h3, 3'h2, h, l);
		chk("cleared count", 10'h000, {h[1:0], l});
		$display("test done: pause and on");
		r = 10'(1 + ($random(seed) & 63));
		wr(3'h0, 8'h00);
		wr(3'h1, 8'hA8);
		wr(3'h4, r[7:0]);
		wr(3'h5, 8'h00);
		wr(3'h0, 8'h19);
		wait_irq(1'b1, g);
		m = 0;
		// Active high while the count is below compare A, over one 129-tick period
		repeat (129) begin
			@(posedge ref_clk);
			#1;
			if (timer_output === 1'b1) m++;
		end
		chk_gap("pwm high cycles", r, m);
		$display("test done: pwm");
		wr(3'h0, 8'h00);
		rd2(3'h6, 3'h6, h, l);
		chk("status flags", 10'h003, 10'(h));
		wr(3'h6, 8'h03);
		rd2(3'h6, 3'h6, h, l);
		chk("cleared flags", 10'h000, 10'(l));
		$display("test done: status");
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
